// File: core/cbu_branch_unit.sv
// Conditional branch unit: runs relative branches over the memory bus.
// Assumes synchronous program memory answering in the same cycle,
// and flags supplied by the arithmetic logic on the same clock.
`timescale 1ns/1ps
// Contract
// RQ1 - Signed ge: branch when N xor V clear
// RQ2 - Signed gt: branch when Z or (N^V) clear
// RQ3 - Unsigned higher: branch when C or Z clear
// RQ4 - Taken: PC = op+2+offset, else op+2
// RQ5 - Three reads: opcode, offset, dummy FFFF
// RQ6 - Condition code register never modified
// RQ7 - Decode le, lt, equal, not equal
// RQ8 - Decode lower-or-same, carry set, carry clear
// RQ9 - Decode minus, plus, overflow, always, never
// RQ10 - Offset sign-extended to sixteen bits
module cbu_branch_unit
    import cbu_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              clk_en,
    // Memory bus
    output logic [cbu_pkg::CBU_AW-1:0] bus_addr,
    output logic                   bus_rw,
    input  wire logic [cbu_pkg::CBU_DW-1:0] bus_rdata,
    // Flags
    input  wire logic [7:0]        ccr_in,
    output logic [7:0]             ccr_out,
    // Program counter
    output logic [cbu_pkg::CBU_AW-1:0] pc,
    output logic                   branch_taken,
    output logic                   illegal_op
);
    cbu_state_e        state_reg;
    logic [15:0]       op_addr_reg;
    logic [7:0]        opcode_reg;
    logic [7:0]        offset_reg;
    logic              taken;
    logic              is_branch;
    logic [15:0]       rel_ext;
    logic [15:0]       pc_next;

    assign is_branch = bus_rdata[7:4] == OP_BRANCH_ALWAYS[7:4];

    cbu_cond_eval u_eval (
        .opcode (opcode_reg),
        .condition_code_register    (ccr_in),
        .taken  (taken)
    );

    // RQ10 sign extension
    assign rel_ext = {{(CBU_AW - CBU_DW){offset_reg[CBU_DW-1]}}, offset_reg};
    // RQ4 target select
    assign pc_next = taken ? op_addr_reg + CBU_PC_STEP + rel_ext
                           : op_addr_reg + CBU_PC_STEP;

    // RQ5 read sequencer
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg   <= CBU_ST_FETCH;
            opcode_reg  <= CBU_DATA_RESET;
            offset_reg  <= CBU_DATA_RESET;
            op_addr_reg <= CBU_PC_RESET;
        end else if (clk_en) begin
            case (state_reg)
                CBU_ST_FETCH: begin
                    op_addr_reg <= pc;
                    opcode_reg  <= bus_rdata;
                    if (is_branch) begin
                        state_reg <= CBU_ST_OFFSET;
                    end
                end
                CBU_ST_OFFSET: begin
                    offset_reg <= bus_rdata;
                    state_reg  <= CBU_ST_DUMMY;
                end
                CBU_ST_DUMMY: state_reg <= CBU_ST_FETCH;
                default:      state_reg <= CBU_ST_FETCH;
            endcase
        end
    end

    // Bus address, always a read
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bus_addr <= CBU_PC_RESET;
            bus_rw   <= 1'b1;
        end else if (clk_en) begin
            bus_rw <= 1'b1;
            case (state_reg)
                // Same step either way; a skipped opcode is one byte
                CBU_ST_FETCH:  bus_addr <= pc + CBU_OPR_STEP;
                // RQ5 dummy cycle address
                CBU_ST_OFFSET: bus_addr <= CBU_DUMMY_ADDR;
                CBU_ST_DUMMY:  bus_addr <= pc_next;
                default:       bus_addr <= pc;
            endcase
        end
    end

    // RQ4 program counter update
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pc           <= CBU_PC_RESET;
            branch_taken <= 1'b0;
            illegal_op   <= 1'b0;
        end else if (clk_en) begin
            branch_taken <= 1'b0;
            illegal_op   <= 1'b0;
            case (state_reg)
                // Non-branch opcodes are skipped; full decoder lives elsewhere
                CBU_ST_FETCH: begin
                    pc         <= pc + CBU_OPR_STEP;
                    illegal_op <= ~is_branch;
                end
                CBU_ST_DUMMY: begin
                    pc           <= pc_next;
                    branch_taken <= taken;
                end
                default: pc <= pc;
            endcase
        end
    end

    // RQ6 flags pass through untouched
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ccr_out <= CBU_DATA_RESET;
        end else if (clk_en) begin
            ccr_out <= ccr_in;
        end
    end

    AST_DUMMY_READ: assert property (@(posedge clk_sys) // RQ5
        disable iff (reset)
        clk_en && state_reg == CBU_ST_OFFSET |=> bus_addr == CBU_DUMMY_ADDR
        && bus_rw)
        else $error("dummy read not at FFFF");

    AST_THREE_CYCLES: assert property (@(posedge clk_sys) // RQ5
        disable iff (reset)
        clk_en && state_reg == CBU_ST_FETCH && is_branch ##1 clk_en
        |-> ##1 clk_en |-> ##1 state_reg == CBU_ST_FETCH)
        else $error("branch not three cycles");

    AST_ALWAYS_READ: assert property (@(posedge clk_sys) // RQ5
        disable iff (reset)
        bus_rw)
        else $error("write cycle issued");

    AST_OFFSET_ADDR: assert property (@(posedge clk_sys) // RQ5
        disable iff (reset)
        clk_en && state_reg == CBU_ST_FETCH && is_branch |=>
        bus_addr == $past(bus_addr) + CBU_OPR_STEP)
        else $error("offset not read from next address");

    AST_HOLD: assert property (@(posedge clk_sys) // RQ5
        disable iff (reset)
        !clk_en |=> $stable(pc) && $stable(bus_addr) && $stable(state_reg))
        else $error("state moved while enable low");

    AST_SKIP: assert property (@(posedge clk_sys) // RQ5
        disable iff (reset)
        clk_en && state_reg == CBU_ST_FETCH && !is_branch |=>
        illegal_op && state_reg == CBU_ST_FETCH)
        else $error("unknown opcode not skipped");

    AST_FETCH_AT_PC: assert property (@(posedge clk_sys) // RQ4
        disable iff (reset)
        state_reg == CBU_ST_FETCH |-> bus_addr == pc)
        else $error("fetch not at program counter");

    AST_TARGET: assert property (@(posedge clk_sys) // RQ4
        disable iff (reset)
        clk_en && state_reg == CBU_ST_DUMMY && taken |=> pc ==
        $past(op_addr_reg) + CBU_PC_STEP + {{8{$past(offset_reg[7])}},
        $past(offset_reg)})
        else $error("taken target wrong");

    AST_FALLTHRU: assert property (@(posedge clk_sys) // RQ4
        disable iff (reset)
        clk_en && state_reg == CBU_ST_DUMMY && !taken |=>
        pc == $past(op_addr_reg) + CBU_PC_STEP)
        else $error("fall-through wrong");

    AST_TAKEN_PULSE: assert property (@(posedge clk_sys) // RQ4
        disable iff (reset)
        clk_en && branch_taken |=> !branch_taken)
        else $error("taken pulse too long");

    AST_CCR_KEEP: assert property (@(posedge clk_sys) // RQ6
        disable iff (reset)
        clk_en |=> ccr_out == $past(ccr_in))
        else $error("flags changed");

    AST_GE: assert property (@(posedge clk_sys) // RQ1
        disable iff (reset)
        opcode_reg == OP_BRANCH_SIGNED_GE |-> taken ==
        !(ccr_in[CBU_BIT_N] ^ ccr_in[CBU_BIT_V]))
        else $error("ge decision wrong");

    AST_GT: assert property (@(posedge clk_sys) // RQ2
        disable iff (reset)
        opcode_reg == OP_BRANCH_SIGNED_GT |-> taken == !(ccr_in[CBU_BIT_Z]
        | (ccr_in[CBU_BIT_N] ^ ccr_in[CBU_BIT_V])))
        else $error("gt decision wrong");

    AST_HI: assert property (@(posedge clk_sys) // RQ3
        disable iff (reset)
        opcode_reg == OP_BRANCH_UNSIGNED_HIGHER |-> taken ==
        !(ccr_in[CBU_BIT_C] | ccr_in[CBU_BIT_Z]))
        else $error("higher decision wrong");

    AST_EQUAL: assert property (@(posedge clk_sys) // RQ7
        disable iff (reset)
        opcode_reg == OP_BRANCH_EQUAL |-> taken == ccr_in[CBU_BIT_Z])
        else $error("equal decision wrong");

    AST_LE: assert property (@(posedge clk_sys) // RQ7
        disable iff (reset)
        opcode_reg == OP_BRANCH_SIGNED_LE |-> taken == (ccr_in[CBU_BIT_Z]
        | (ccr_in[CBU_BIT_N] ^ ccr_in[CBU_BIT_V])))
        else $error("le decision wrong");

    AST_LOWER_SAME: assert property (@(posedge clk_sys) // RQ8
        disable iff (reset)
        opcode_reg == OP_BRANCH_LOWER_OR_SAME |-> taken ==
        (ccr_in[CBU_BIT_C] | ccr_in[CBU_BIT_Z]))
        else $error("lower-or-same decision wrong");

    AST_ALWAYS: assert property (@(posedge clk_sys) // RQ9
        disable iff (reset)
        opcode_reg == OP_BRANCH_ALWAYS |-> taken)
        else $error("always branch not taken");

    AST_NEVER: assert property (@(posedge clk_sys) // RQ9
        disable iff (reset)
        opcode_reg == OP_BRANCH_NEVER |-> !taken)
        else $error("never branch taken");

    AST_NEVER_PC: assert property (@(posedge clk_sys) // RQ9
        disable iff (reset)
        clk_en && state_reg == CBU_ST_DUMMY && opcode_reg == OP_BRANCH_NEVER
        |=> !branch_taken && pc == $past(op_addr_reg) + CBU_PC_STEP)
        else $error("never branch moved off fall-through");

    AST_SIGN: assert property (@(posedge clk_sys) // RQ10
        disable iff (reset)
        clk_en && state_reg == CBU_ST_OFFSET |=>
        rel_ext == {{8{$past(bus_rdata[7])}}, $past(bus_rdata)})
        else $error("offset not sign-extended");
endmodule // cbu_branch_unit

// File: core/cbu_pkg.sv
// Package for the conditional branch unit: opcodes, addresses, flag bits.
// Assumes an 8-bit data, 16-bit address processor bus.
package cbu_pkg;
    localparam int          CBU_AW         = 16;
    localparam int          CBU_DW         = 8;
    localparam logic [15:0] CBU_DUMMY_ADDR = 16'hFFFF;
    localparam logic [15:0] CBU_PC_STEP    = 16'h0002;
    localparam logic [15:0] CBU_OPR_STEP   = 16'h0001;
    localparam logic [15:0] CBU_PC_RESET   = 16'h0000;
    localparam logic [7:0]  CBU_DATA_RESET = 8'h00;
    // Condition code register bit positions
    localparam int CBU_BIT_C = 0;
    localparam int CBU_BIT_V = 1;
    localparam int CBU_BIT_Z = 2;
    localparam int CBU_BIT_N = 3;
    // Branch opcodes
    localparam logic [7:0] OP_BRANCH_ALWAYS         = 8'h20;
    localparam logic [7:0] OP_BRANCH_NEVER          = 8'h21;
    localparam logic [7:0] OP_BRANCH_UNSIGNED_HIGHER = 8'h22;
    localparam logic [7:0] OP_BRANCH_LOWER_OR_SAME  = 8'h23;
    localparam logic [7:0] OP_BRANCH_CARRY_CLEAR    = 8'h24;
    localparam logic [7:0] OP_BRANCH_CARRY_SET      = 8'h25;
    localparam logic [7:0] OP_BRANCH_NOT_EQUAL      = 8'h26;
    localparam logic [7:0] OP_BRANCH_EQUAL          = 8'h27;
    localparam logic [7:0] OP_BRANCH_OVERFLOW_CLEAR = 8'h28;
    localparam logic [7:0] OP_BRANCH_OVERFLOW_SET   = 8'h29;
    localparam logic [7:0] OP_BRANCH_PLUS           = 8'h2A;
    localparam logic [7:0] OP_BRANCH_MINUS          = 8'h2B;
    localparam logic [7:0] OP_BRANCH_SIGNED_GE      = 8'h2C;
    localparam logic [7:0] OP_BRANCH_SIGNED_LT      = 8'h2D;
    localparam logic [7:0] OP_BRANCH_SIGNED_GT      = 8'h2E;
    localparam logic [7:0] OP_BRANCH_SIGNED_LE      = 8'h2F;
    // Sequence states, Gray along fetch, offset, dummy
    typedef enum logic [1:0] {
        CBU_ST_FETCH  = 2'b00,
        CBU_ST_OFFSET = 2'b01,
        CBU_ST_DUMMY  = 2'b11
    } cbu_state_e;
endpackage

// File: core/cbu_cond_eval.sv
// Branch condition evaluator: opcode and flags to taken decision.
// Assumes the caller has already checked that the opcode is a branch.
`timescale 1ns/1ps
module cbu_cond_eval
    import cbu_pkg::*;
(
    // Decode inputs
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] condition_code_register,
    // Decision
    output logic            taken
);
    logic c;
    logic v;
    logic z;
    logic n;
    assign c = condition_code_register[CBU_BIT_C];
    assign v = condition_code_register[CBU_BIT_V];
    assign z = condition_code_register[CBU_BIT_Z];
    assign n = condition_code_register[CBU_BIT_N];

    always_comb begin
        case (opcode)
            // RQ1 signed ge test
            OP_BRANCH_SIGNED_GE:       taken = (n ^ v) == 1'b0;
            // RQ2 signed gt test
            OP_BRANCH_SIGNED_GT:       taken = (z | (n ^ v)) == 1'b0;
            // RQ3 unsigned higher test
            OP_BRANCH_UNSIGNED_HIGHER: taken = (c | z) == 1'b0;
            // RQ7 other signed tests and equality tests
            OP_BRANCH_SIGNED_LE:       taken = z | (n ^ v);
            OP_BRANCH_SIGNED_LT:       taken = n ^ v;
            OP_BRANCH_EQUAL:           taken = z;
            OP_BRANCH_NOT_EQUAL:       taken = ~z;
            // RQ8 carry based tests
            OP_BRANCH_LOWER_OR_SAME:   taken = c | z;
            OP_BRANCH_CARRY_SET:       taken = c;
            OP_BRANCH_CARRY_CLEAR:     taken = ~c;
            // RQ9 single flag, unconditional
            OP_BRANCH_MINUS:           taken = n;
            OP_BRANCH_PLUS:            taken = ~n;
            OP_BRANCH_OVERFLOW_SET:    taken = v;
            OP_BRANCH_OVERFLOW_CLEAR:  taken = ~v;
            OP_BRANCH_ALWAYS:          taken = 1'b1;
            OP_BRANCH_NEVER:           taken = 1'b0;
            default:                   taken = 1'b0;
        endcase
    end
endmodule // cbu_cond_eval

// File: sim/cbu_prog_mem.sv
// Program memory model for the conditional branch unit bench.
// Assumes reads answer in the same cycle; the bench preloads bytes.
`timescale 1ns/1ps
module cbu_prog_mem (
    // Memory bus
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rw,
    output logic [7:0]       bus_rdata
);
    logic [7:0] mem [0:65535];

    // Filler pattern, so stale bytes look like a clean zero only at addresses whose low byte is A5
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end

    // Writes are not modelled; a write cycle returns inverted data
    assign bus_rdata = bus_rw ? mem[bus_addr] : ~mem[bus_addr];
endmodule // cbu_prog_mem

// File: sim/cbu_branch_unit_tb.sv
// Self-checking bench for the conditional branch unit.
// Assumes the program memory model and a free-running 25 MHz clock.
`timescale 1ns/1ps
module cbu_branch_unit_tb;
    import cbu_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        clk_en  = 1'b1;
    logic [7:0]  ccr_in  = 8'h00;
    logic [15:0] bus_addr, pc, exp_pc;
    logic [7:0]  bus_rdata, ccr_out;
    logic        bus_rw, branch_taken, illegal_op;
    int          n_errors = 0;
    int          total_checks = 0;

    always #20 clk_sys = ~clk_sys;

    cbu_branch_unit uut (.clk_sys(clk_sys), .reset(reset),
        .clk_en(clk_en), .bus_addr(bus_addr), .bus_rw(bus_rw),
        .bus_rdata(bus_rdata), .ccr_in(ccr_in), .ccr_out(ccr_out),
        .pc(pc), .branch_taken(branch_taken), .illegal_op(illegal_op));
    cbu_prog_mem mem_i (.bus_addr(bus_addr), .bus_rw(bus_rw),
        .bus_rdata(bus_rdata));

    task automatic chk(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Random stalls keep the enable path exercised
    task automatic tick;
        @(posedge clk_sys);
        #2 clk_en = ($urandom_range(3) != 0);
    endtask

    task automatic wait_en;
        while (!clk_en) tick();
    endtask

    function automatic logic exp_take(input logic [7:0] op, f);
        logic c, v, z, n;
        c = f[CBU_BIT_C];
        v = f[CBU_BIT_V];
        z = f[CBU_BIT_Z];
        n = f[CBU_BIT_N];
        case (op)
            8'h20: return 1'b1;
            8'h21: return 1'b0;
            8'h22: return !(c | z);
            8'h23: return c | z;
            8'h24: return !c;
            8'h25: return c;
            8'h26: return !z;
            8'h27: return z;
            8'h28: return !v;
            8'h29: return v;
            8'h2A: return !n;
            8'h2B: return n;
            8'h2C: return !(n ^ v);
            8'h2D: return n ^ v;
            8'h2E: return !(z | (n ^ v));
            default: return z | (n ^ v);
        endcase
    endfunction

    task automatic run_op(input logic [7:0] op, off, f);
        logic [15:0] nxt;
        logic        tk;
        tk  = exp_take(op, f);
        nxt = exp_pc + CBU_PC_STEP + (tk ? {{8{off[7]}}, off} : 16'h0000);
        mem_i.mem[exp_pc] = op;
        mem_i.mem[exp_pc + 16'h0001] = off;
        ccr_in = f;
        wait_en();
        chk("fetch addr", bus_addr, exp_pc);
        chk("read strobe", {15'h0000, bus_rw}, 16'h0001);
        tick();
        wait_en();
        chk("offset addr", bus_addr, exp_pc + 16'h0001);
        tick();
        wait_en();
        chk("dummy addr", bus_addr, CBU_DUMMY_ADDR);
        tick();
        chk("pc", pc, nxt);
        chk("taken", 16'(branch_taken), 16'(tk));
        chk("flags", {8'h00, ccr_out}, {8'h00, f});
        chk("branch flagged illegal", 16'(illegal_op), 16'h0000);
        exp_pc = nxt;
    endtask

    // Opcodes outside the branch group are skipped one byte
    task automatic run_bad(input logic [7:0] op);
        mem_i.mem[exp_pc] = op;
        wait_en();
        tick();
        chk("illegal", {15'h0000, illegal_op}, 16'h0001);
        chk("skip pc", pc, exp_pc + CBU_OPR_STEP);
        exp_pc = exp_pc + CBU_OPR_STEP;
    endtask

    initial begin
        void'($urandom(32'h3682));
        exp_pc = CBU_PC_RESET;
        repeat (12) @(posedge clk_sys);
        chk("reset pc", pc, CBU_PC_RESET);
        #2 reset = 1'b0;
        // Every opcode against every flag pattern, offset extremes
        for (int o = 0; o < 16; o++) begin
            for (int f = 0; f < 16; f++) begin
                run_op(8'h20 + 8'(o), f[0] ? 8'h80 : 8'h7F,
                       {4'($urandom), 4'(f)});
            end
        end
        run_bad(8'h12);
        // Just outside the branch group on both sides
        run_bad(8'h1F);
        run_bad(8'h30);
        run_op(8'h20, 8'hFE, 8'h00);
        // Reset in mid-instruction
        tick();
        reset = 1'b1;
        #1 chk("reset addr", bus_addr, CBU_PC_RESET);
        chk("reset pc", pc, CBU_PC_RESET);
        chk("reset flags", {8'h00, ccr_out}, 16'h0000);
        @(posedge clk_sys);
        #2 reset = 1'b0;
        exp_pc = CBU_PC_RESET;
        for (int i = 0; i < 300; i++) begin
            if ($urandom_range(9) == 0) begin
                run_bad(8'($urandom_range(31)));
            end else begin
                run_op(8'h20 + 8'($urandom_range(15)), 8'($urandom),
                       8'($urandom));
            end
        end
        wrap_up();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        wrap_up();
    end
endmodule // cbu_branch_unit_tb
